// *** hdl/dac_route_pkg.sv ***
// constants for the dac input format and routing block
// assumes an apb master on pclk and one external serial audio source
package dac_route_pkg;

   // datapath shape
   localparam int LANES = 3;
   localparam int SAMPLE_W = 24;
   localparam int FRAME_W = LANES * 2 * SAMPLE_W;
   localparam int FIFO_DEPTH = 8;
   localparam int SHIFT_W = 32;

   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_OSR = 8'h0c;
   localparam logic [7:0] IDX_ROUTE = 8'h0f;
   localparam logic [7:0] IDX_IFACE = 8'h09;
   localparam logic [7:0] IDX_STATUS = 8'h0a;
   localparam logic [7:0] ADDR_OSR = {IDX_OSR[5:0], 2'h0};
   localparam logic [7:0] ADDR_ROUTE = {IDX_ROUTE[5:0], 2'h0};
   localparam logic [7:0] ADDR_IFACE = {IDX_IFACE[5:0], 2'h0};
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};

   // field positions and reset values
   localparam int OSR_BIT = 6;
   localparam int OVF_BIT = 1;
   localparam logic [8:0] OSR_RST = 9'h000;
   localparam logic [8:0] ROUTE_RST = 9'h024;
   localparam logic [3:0] IFACE_RST = 4'h8;

   // serial formats held in the interface register
   typedef enum logic [1:0] {
      FMT_I2S = 2'h0,
      FMT_LJ = 2'h1,
      FMT_RJ = 2'h2
   } fmt_type;

   // word length codes and the unused select code
   localparam logic [1:0] WL_16 = 2'h0;
   localparam logic [1:0] WL_20 = 2'h1;
   localparam logic [1:0] WL_24 = 2'h2;
   localparam logic [1:0] WL_32 = 2'h3;
   localparam logic [1:0] SEL_NONE = 2'h3;

   // bit counts
   localparam logic [5:0] I2S_OFFSET = 6'h01;
   localparam logic [6:0] AUTO_FRAME_BITS = 7'h20;
   localparam logic [5:0] CNT_MAX = 6'h3f;

endpackage

// *** hdl/stream_if.sv ***
// valid/ready stream carrying one stereo frame for all dacs
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int W = 144);
   logic valid; // word offered
   logic ready; // word can be taken
   logic [W-1:0] data; // frame word
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/frame_fifo.sv ***
// frame fifo between the serial receiver and the dac side
// assumes depth is a power of two and a single clock
`timescale 1ns/1ns
`default_nettype none
module frame_fifo #(
   parameter int W = 144,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   stream_if.snk in_s,
   stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [W-1:0] mem [DEPTH]; // frame storage
   logic [AW-1:0] wp; // write pointer
   logic [AW-1:0] rp; // read pointer
   logic [AW:0] cnt; // words held
   logic push; // word written this cycle
   logic pop; // word read this cycle

   // honest flags straight from the fill count
   assign in_s.ready = (cnt != FULL);
   assign out_s.valid = (cnt != '0);
   assign out_s.data = mem[rp];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   // storage needs no reset, only the pointers and count do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_s.data;
      end
   end

   // pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   property p_fifo_bound;
      @(posedge clk) disable iff (!rst_n)
      push && !pop |=> cnt == $past(cnt) + 1'b1 && cnt <= FULL;
   endproperty
   a_fifo_bound: assert property (p_fifo_bound)
      else $error("fifo count did not follow a push");

endmodule
`default_nettype wire

// *** hdl/dac_input_route.sv ***
// input side of the primary audio receiver for three stereo dacs
// assumes apb on pclk and a slow bit clock from the far source
//
// Overview of operation
// [RULE1] right justified with code 11 uses 24 bits
// [RULE2] samples are signed two's complement
// [RULE3] short words padded with zero low bits
// [RULE4] 32-bit words drop their lowest 8 bits
// [RULE5] i2s 24 takes widths up to 24
// [RULE6] i2s 24 frame of 32 clocks means 16
// [RULE7] each dac selects one of three pins
// [RULE8] select fields at 1:0 3:2 5:4
// [RULE9] oversample bit: 0 is 128x, 1 is 64x
// [RULE10] host picks 64x at 128 or 192 fs
// [RULE11] host picks 128x from 256 to 1152 fs
// [RULE12] oversample bit six, resets to zero
// [RULE13] select code 11 feeds zero samples
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dac_input_route
   import dac_route_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic data_in_one,
   input wire logic data_in_two,
   input wire logic data_in_three,
   output logic out_valid,
   output logic [FRAME_W-1:0] out_data,
   input wire logic out_ready,
   output logic dac_oversample_rate
);

   // register state
   logic [8:0] osr_reg; // oversample control word
   logic [8:0] route_reg; // dac input routing word
   logic [3:0] iface_reg; // format and word length
   logic auto16; // frame of 32 clocks seen in i2s 24
   logic overflow; // frame lost on a full fifo

   // bus decode
   logic setup; // apb setup cycle
   logic wr_fire; // write takes effect now
   logic hit; // address is mapped
   logic [31:0] rd_mux; // read value for the address

   // link synchronisers
   logic bclk_m, bclk_s, bclk_d;
   logic lr_m, lr_s;
   logic [LANES-1:0] din_m; // first stage, read by second only
   logic [LANES-1:0] din_s; // synchronised pins

   // frame tracking shared by all lanes
   logic bclk_rise; // bit clock rising edge seen
   logic lr_prev; // frame clock at previous bit
   logic half_end; // a half frame has just closed
   logic ending_left; // the closing half was the left one
   logic [5:0] cnt; // bits in the current half
   logic [5:0] left_n; // bits in the last left half
   logic frame_valid; // both halves captured
   fmt_type fmt; // current format
   logic [1:0] wl_code; // programmed length code
   logic rj; // right justified selected
   logic i2s24; // i2s with 24-bit words
   logic [5:0] eff_wl; // word length actually used
   logic [5:0] off; // idle bits before the msb

   // per-lane data
   logic [LANES-1:0] lane_bit; // routed serial bit
   logic [SHIFT_W-1:0] sh [LANES]; // collected bits
   logic [SAMPLE_W-1:0] left_w [LANES]; // last left sample
   logic [SAMPLE_W-1:0] right_w [LANES]; // last right sample
   logic [FRAME_W-1:0] frame; // packed frame for the fifo

   stream_if #(.W(FRAME_W)) push_if ();
   stream_if #(.W(FRAME_W)) pop_if ();

   assign fmt = fmt_type'(iface_reg[1:0]);
   assign wl_code = iface_reg[3:2];
   assign rj = (fmt == FMT_RJ);
   assign i2s24 = (fmt == FMT_I2S) && (wl_code == WL_24);
   assign off = (fmt == FMT_I2S) ? I2S_OFFSET : 6'h00;

   // apb: zero wait states, pready rises in the access cycle
   assign setup = psel && !penable;
   assign wr_fire = psel && penable && pwrite && pready;

   // read mux; unmapped addresses read zero and flag an error
   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         ADDR_OSR: begin
            rd_mux = {23'h0, osr_reg};
         end
         ADDR_ROUTE: begin
            rd_mux = {23'h0, route_reg};
         end
         ADDR_IFACE: begin
            rd_mux = {28'h0, iface_reg};
         end
         ADDR_STATUS: begin
            rd_mux = {30'h0, overflow, auto16};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // bus answer registers, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osr_reg <= OSR_RST; // starts in 128x [RULE12]
         route_reg <= ROUTE_RST; // each dac on its own pin [RULE8]
         iface_reg <= IFACE_RST;
      end else if (wr_fire) begin
         if (paddr == ADDR_OSR) begin
            osr_reg <= pwdata[8:0];
         end
         if (paddr == ADDR_ROUTE) begin
            route_reg <= pwdata[8:0];
         end
         if (paddr == ADDR_IFACE) begin
            iface_reg <= pwdata[3:0];
         end
      end
   end

   // oversample rate pin; host owns the choice against mclk ratio
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_oversample_rate <= 1'b0;
      end else begin
         dac_oversample_rate <= osr_reg[OSR_BIT]; // 1 means 64x [RULE9]
      end
   end

   // overflow flag: a lost frame wins over a clearing write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow <= 1'b0;
      end else if (push_if.valid && !push_if.ready) begin
         overflow <= 1'b1;
      end else if (wr_fire && paddr == ADDR_STATUS && pwdata[OVF_BIT]) begin
         overflow <= 1'b0;
      end
   end

   // two-stage synchronisers for every pin, a third for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bclk_m <= 1'b0;
         bclk_s <= 1'b0;
         bclk_d <= 1'b0;
         lr_m <= 1'b0;
         lr_s <= 1'b0;
         din_m <= '0;
         din_s <= '0;
      end else begin
         bclk_m <= bclk;
         bclk_s <= bclk_m;
         bclk_d <= bclk_s;
         lr_m <= lrclk;
         lr_s <= lr_m;
         din_m <= {data_in_three, data_in_two, data_in_one};
         din_s <= din_m;
      end
   end

   assign bclk_rise = bclk_s && !bclk_d;
   assign half_end = bclk_rise && (lr_s != lr_prev);
   // i2s carries left while the frame clock is low, others while high
   assign ending_left = (fmt == FMT_I2S) ? !lr_prev : lr_prev;

   // word length in use
   always_comb begin
      unique case (wl_code)
         WL_16: eff_wl = 6'd16;
         WL_20: eff_wl = 6'd20;
         WL_24: eff_wl = 6'd24;
         WL_32: eff_wl = 6'd32;
      endcase
      if (rj && wl_code == WL_32) begin
         eff_wl = 6'd24; // no 32-bit right justified [RULE1]
      end
      if (i2s24 && auto16) begin
         eff_wl = 6'd16; // detected short frame [RULE6]
      end
   end

   // bit counting per half frame, saturating on long halves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lr_prev <= 1'b0;
         cnt <= 6'h00;
         left_n <= 6'h00;
      end else if (bclk_rise) begin
         lr_prev <= lr_s;
         if (half_end) begin
            cnt <= 6'h01;
            if (ending_left) begin
               left_n <= cnt;
            end
         end else if (cnt != CNT_MAX) begin
            cnt <= cnt + 6'h01;
         end
      end
   end

   // length detection over a whole left plus right period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto16 <= 1'b0;
      end else if (!i2s24) begin
         auto16 <= 1'b0;
      end else if (half_end && !ending_left) begin
         // any width up to 24 is taken msb first [RULE5]
         auto16 <= ({1'b0, left_n} + {1'b0, cnt}) == AUTO_FRAME_BITS; // [RULE6]
      end
   end

   // pull one sample out of the collected bits and align to 24 bits;
   // the word msb lands on bit 23 so the sign survives [RULE2]
   function automatic logic [SAMPLE_W-1:0] extract(
      input logic [SHIFT_W-1:0] bits,
      input logic [5:0] n,
      input logic rjust,
      input logic [5:0] lead,
      input logic [5:0] wl,
      input logic cur
   );
      logic [SHIFT_W-1:0] v;
      logic [6:0] have;
      logic [6:0] need;
      have = (n > 6'd32) ? 7'd32 : {1'b0, n};
      need = {1'b0, lead} + {1'b0, wl};
      if (rjust) begin
         v = bits;
      end else if (have >= need) begin
         v = bits >> (have - need);
      end else begin
         // an i2s word that fills its half ends on the next half's first
         // bit, so that bit is taken as the lsb
         v = {bits[SHIFT_W-2:0], cur} << (need - have - 7'd1);
      end
      // left align: pads short words, drops low byte of 32 [RULE3] [RULE4]
      v = v << (6'd32 - wl);
      return v[SHIFT_W-1:8];
   endfunction

   // one serial lane per dac
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [1:0] sel; // source select for this dac
      assign sel = route_reg[2*l+1:2*l];
      // unused code feeds silence [RULE13]
      assign lane_bit[l] = (sel == SEL_NONE) ? 1'b0 : din_s[sel]; // [RULE7]

      // right justified keeps shifting so the lsb ends at bit 0
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sh[l] <= '0;
         end else if (half_end) begin
            sh[l] <= {31'h0, lane_bit[l]};
         end else if (bclk_rise && (rj || cnt < 6'd32)) begin
            sh[l] <= {sh[l][SHIFT_W-2:0], lane_bit[l]};
         end
      end

      // capture the closing half
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            left_w[l] <= '0;
            right_w[l] <= '0;
         end else if (half_end) begin
            if (ending_left) begin
               left_w[l] <= extract(sh[l], cnt, rj, off, eff_wl,
                  lane_bit[l]);
            end else begin
               right_w[l] <= extract(sh[l], cnt, rj, off, eff_wl,
                  lane_bit[l]);
            end
         end
      end

      assign frame[(2*l+2)*SAMPLE_W-1:(2*l+1)*SAMPLE_W] = right_w[l];
      assign frame[(2*l+1)*SAMPLE_W-1:2*l*SAMPLE_W] = left_w[l];
   end

   // one-cycle frame strobe after the right half closes;
   // the source cannot be stalled, so a full fifo loses the frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_valid <= 1'b0;
      end else begin
         frame_valid <= half_end && !ending_left;
      end
   end

   assign push_if.valid = frame_valid;
   assign push_if.data = frame;

   frame_fifo #(.W(FRAME_W), .DEPTH(DEPTH)) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_s(push_if),
      .out_s(pop_if)
   );

   // registered output stage so the ports come from flops
   assign pop_if.ready = !out_valid || out_ready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (pop_if.ready) begin
         out_valid <= pop_if.valid;
         if (pop_if.valid) begin
            out_data <= pop_if.data;
         end
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rj_clamp;
      rj && wl_code == WL_32 |-> eff_wl == 6'd24;
   endproperty
   a_rj_clamp: assert property (p_rj_clamp) // [RULE1]
      else $error("right justified 32-bit not clamped");

   property p_pad_zero;
      half_end && eff_wl == 6'd16 |=>
         ($past(ending_left) ? left_w[0][7:0] : right_w[0][7:0]) == 8'h00;
   endproperty
   a_pad_zero: assert property (p_pad_zero) // [RULE3]
      else $error("16-bit sample low bits not zero");

   property p_drop_low;
      half_end && ending_left && fmt == FMT_LJ && eff_wl == 6'd32 &&
         cnt == 6'd32 |=> left_w[0] == $past(sh[0][31:8]);
   endproperty
   a_drop_low: assert property (p_drop_low) // [RULE4]
      else $error("32-bit sample not cut to upper 24");

   property p_auto16;
      half_end && !ending_left && i2s24 &&
         ({1'b0, left_n} + {1'b0, cnt}) == AUTO_FRAME_BITS
         |=> auto16 && eff_wl == 6'd16;
   endproperty
   a_auto16: assert property (p_auto16) // [RULE6]
      else $error("32-clock frame not detected as 16-bit");

   property p_route;
      route_reg[3:2] == 2'h2 |-> lane_bit[1] == din_s[2];
   endproperty
   a_route: assert property (p_route) // [RULE7]
      else $error("dac two not fed from pin three");

   property p_reset_vals;
      $rose(presetn) |-> route_reg[5:0] == 6'h24 && !dac_oversample_rate;
   endproperty
   a_reset_vals: assert property (p_reset_vals) // [RULE8] [RULE12]
      else $error("routing or oversample reset value wrong");

   property p_osr_write;
      wr_fire && paddr == ADDR_OSR |=> ##1
         dac_oversample_rate == $past(pwdata[OSR_BIT], 2);
   endproperty
   a_osr_write: assert property (p_osr_write) // [RULE9]
      else $error("oversample pin does not follow its bit");

   property p_silent_lane;
      route_reg[5:4] == SEL_NONE |-> lane_bit[2] == 1'b0;
   endproperty
   a_silent_lane: assert property (p_silent_lane) // [RULE13]
      else $error("unused select code passed data");

   property p_apb_answer;
      setup |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not one access cycle");

   c_frame: cover property (frame_valid && push_if.ready);
   c_auto16: cover property ($rose(auto16));
   c_overflow: cover property ($rose(overflow));
   c_out: cover property (out_valid && out_ready);

endmodule
`default_nettype wire

// *** verif/audio_source.sv ***
// behavioural serial audio source driving the three data pins
// assumes the bench calls one task at a time; bclk idles low
`timescale 1ns/1ns
`default_nettype none
module audio_source
   import dac_route_pkg::*;
(
   output logic bclk,
   output logic lrclk,
   output logic [2:0] dout
);
   logic [2:0] carry; // i2s bit owed to the following half
   logic [63:0] w; // stream of the pin and half being sent
   initial begin
      bclk = 1'b0;
      lrclk = 1'b0;
      dout = 3'h0;
      carry = 3'h0;
   end
   // park on the right-half level so the next frame shows a change
   task automatic park(input fmt_type f);
      lrclk = (f == FMT_I2S);
      dout = ~dout;
   endtask
   // one stereo frame; clock stands still between frames
   // halves are never shorter than the bench asks
   task automatic send_frame(input fmt_type f, input int nb,
         input logic [383:0] s);
      #7; // keeps bit clock edges off the pclk edges
      for (int h = 0; h < 2; h++) begin
         lrclk = (f != FMT_I2S) ^ h[0]; // i2s left is low, others high
         for (int k = 0; k < nb; k++) begin
            for (int p = 0; p < 3; p++) begin
               w = s[(p * 2 + h) * 64 +: 64]; // signed words
               dout[p] = (f != FMT_I2S) ? w[63 - k] :
                  (k == 0) ? carry[p] : w[64 - k];
            end
            #200 bclk = 1'b1;
            #200 bclk = 1'b0;
         end
         for (int p = 0; p < 3; p++) begin
            w = s[(p * 2 + h) * 64 +: 64];
            carry[p] = w[64 - nb];
         end
      end
      dout = ~dout; // released pin must not keep its last value
   endtask
endmodule
`default_nettype wire

// *** verif/test_dac_input_route.sv ***
// self-checking bench for the dac input format and routing block
// assumes the design package, design and source model compiled first
`timescale 1ns/1ns
`default_nettype none
module test_dac_input_route
   import dac_route_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic bclk, lrclk, out_valid, out_ready, dac_oversample_rate;
   logic [2:0] din;
   logic [FRAME_W-1:0] out_data;
   logic [32:0] rq[$]; // apb notes: error flag and read data
   logic [FRAME_W:0] fq[$]; // frame notes, top bit set when checked
   logic [FRAME_W:0] note, pend; // pend waits for its closing edge
   logic stall, discard, pend_ok;
   logic [5:0] rt;
   int n_errors, n_compared;
   // groups: format, word code, bits per half, bits kept
   int tf[11] = '{0, 0, 0, 0, 0, 0, 2, 2, 2, 2, 1};
   int tw[11] = '{0, 1, 2, 3, 2, 2, 0, 1, 2, 3, 3};
   int tn[11] = '{40, 40, 40, 40, 24, 16, 40, 40, 40, 40, 40};
   int te[11] = '{16, 20, 24, 32, 24, 16, 16, 20, 24, 24, 32};

   dac_input_route #(.DEPTH(FIFO_DEPTH)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bclk(bclk), .lrclk(lrclk),
      .data_in_one(din[0]), .data_in_two(din[1]), .data_in_three(din[2]),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .dac_oversample_rate(dac_oversample_rate));
   audio_source u_src (.bclk(bclk), .lrclk(lrclk), .dout(din));

   always #25 pclk = ~pclk;
   // sink stalls at random, or for good while the buffer is filled
   always @(posedge pclk) out_ready <= !stall && ($urandom % 4 != 0);

   task automatic report(input logic ok);
      n_compared++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: unexpected value", $time);
      end
   endtask
   task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
      report(g === e);
   endtask
   task automatic cmp_frame(input logic [143:0] e, input logic [143:0] g);
      report(g === e);
   endtask
   task automatic cmp_bit(input logic e, input logic g);
      report(g === e);
   endtask

   // settled values are taken at the falling edge
   always @(negedge pclk) begin
      if (psel && penable && pready === 1'b1 && rq.size() > 0)
         cmp_apb(rq.pop_front(), {pslverr, prdata});
      if (out_valid === 1'b1 && out_ready && !discard) begin
         if (fq.size() == 0)
            cmp_bit(1'b0, 1'b1); // frame with no note behind it
         else begin
            note = fq.pop_front();
            if (note[FRAME_W])
               cmp_frame(note[FRAME_W-1:0], out_data);
         end
      end
   end

   // apb master: request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [32:0] e);
      rq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(negedge pclk); while (pready !== 1'b1);
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, {e, 32'h0}); // writes read back zero data
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask

   // sample as the dac should see it: short words get zero low bits
   function automatic logic [23:0] keep(input logic [31:0] r, input int e);
      logic [23:0] m;
      m = (e >= 24) ? 24'hffffff : ~((24'h1 << (24 - e)) - 24'h1);
      return r[31:8] & m;
   endfunction

   // one frame of random words; its note is queued once it is closed
   task automatic frame(input int g, input logic chk);
      logic [191:0] r;
      logic [383:0] s;
      logic [63:0] t;
      logic [FRAME_W-1:0] x;
      logic [1:0] sel;
      for (int i = 0; i < 6; i++) begin
         r[i * 32 +: 32] = $urandom;
         t = {~r[i * 32 +: 32], r[i * 32 +: 32]}; // junk around each word
         s[i * 64 +: 64] = (tf[g] == 2) ? t << (te[g] - 8) :
            {t[31:0], t[63:32]};
      end
      for (int d = 0; d < 3; d++)
         for (int h = 0; h < 2; h++) begin
            sel = rt[d * 2 +: 2];
            x[(d * 2 + h) * 24 +: 24] = (sel == 2'h3) ? 24'h0 :
               keep(r[(int'(sel) * 2 + h) * 32 +: 32], te[g]);
         end
      if (pend_ok)
         fq.push_back(pend);
      pend = {chk, x};
      pend_ok = 1'b1;
      u_src.send_frame(fmt_type'(tf[g]), tn[g], s);
   endtask

   task automatic do_reset(input int g);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      fq.delete();
      pend_ok = 1'b0;
      presetn <= 1'b1;
      u_src.park(fmt_type'(tf[g]));
   endtask

   task automatic give_verdict();
      if (n_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // a hang is cut short well past the expected run length
   initial begin
      #4000000;
      n_errors++;
      give_verdict();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      out_ready = 1'b0;
      stall = 1'b0;
      discard = 1'b0;
      void'($urandom(32'h8a9a));
      for (int g = 0; g < 11; g++) begin
         do_reset(g);
         rt = (g == 0) ? 6'h24 : (g == 1) ? 6'h39 : 6'($urandom);
         if (g == 0) begin
            rd(ADDR_OSR, {24'h0, OSR_RST});
            rd(ADDR_ROUTE, {24'h0, ROUTE_RST});
            rd(8'h00, {1'b1, 32'h0}); // unmapped read is refused
            wr(8'hfc, 32'h1, 1'b1); // unmapped write is refused
            for (int v = 1; v >= 0; v--) begin
               wr(ADDR_OSR, {32{v[0]}}, 1'b0);
               repeat (2) @(negedge pclk);
               cmp_bit(v[0], dac_oversample_rate);
               rd(ADDR_OSR, {24'h0, {9{v[0]}}});
            end
         end else begin
            wr(ADDR_ROUTE, {26'h0, rt}, 1'b0);
            rd(ADDR_ROUTE, {27'h0, rt});
         end
         wr(ADDR_IFACE, {28'h0, tw[g][1:0], tf[g][1:0]}, 1'b0);
         discard = 1'b1; // the first frame after reset may be junk
         frame(g, 1'b0);
         discard = 1'b0;
         frame(g, 1'b0);
         repeat (2) frame(g, 1'b1);
         if (g == 2) begin
            stall = 1'b1; // fill the buffer until it refuses
            repeat (11) frame(g, 1'b0);
            rd(ADDR_STATUS, {1'b0, 32'h2});
            stall = 1'b0;
            repeat (100) @(negedge pclk);
            cmp_bit(1'b0, out_valid); // drained
            fq.delete(); // notes of dropped frames
            wr(ADDR_STATUS, 32'h2, 1'b0);
            rd(ADDR_STATUS, 33'h0);
         end
         frame(g, 1'b0); // closes the last checked frame, or in group 2 the last stalled one
         for (int i = 0; i < 400 && fq.size() > 0; i++)
            @(posedge pclk);
         cmp_bit(1'b1, fq.size() == 0);
         rd(ADDR_STATUS, {32'h0, g == 5});
      end
      give_verdict();
   end
endmodule
`default_nettype wire
